// ===== src/swevt_consts.vh
`ifndef SWEVT_CONSTS_VH
`define SWEVT_CONSTS_VH
// Behaviour
// - Writing 1 to trigger_generate produces a trigger event and sets trigger_flag, interrupting if enabled.
// - Each generate bit is set only by software and cleared by hardware once its event is produced.
// - With channel 1 as output, writing channel1_event_generate sets channel1_flag, interrupting if enabled.
// - With channel 1 as input, the forced event copies the counter into capture register 1 and sets channel1_flag.
// - A forced capture on channel 1 while channel1_flag is set also sets the over-capture flag.
// - channel2_event_generate behaves for channel 2 as channel 1's forced event does.
// - Writing 1 to update_generate reinitialises the counter and produces an update event; 0 does nothing.
// - A forced update clears the prescaler count but keeps the division coefficient.
// - In up mode a forced update clears the counter to zero.
// - In down mode a forced update loads the counter with the auto-reload value.
// - A forced update counts as an update event only while update_request_source and update_disable are 0.
// - Over-capture flags stay set until software writes 0; hardware only sets them.

// ==========================================
// Register byte offsets
`define OFS_SWEVT   12'h000
`define OFS_STATUS  12'h004
`define OFS_MASK    12'h008
`define OFS_CTRL    12'h00C
`define OFS_CNT     12'h010
`define OFS_ARR     12'h014
`define OFS_PSC     12'h018
`define OFS_CCR1    12'h01C
`define OFS_CCR2    12'h020
`define OFS_FLAGS   12'h024

// ==========================================
// Field positions
`define BIT_UG      0
`define BIT_CHANNEL1_EVENT_GENERATE    1
`define BIT_CHANNEL2_EVENT_GENERATE    2
`define BIT_TG      6
`define BIT_UIF     0
`define BIT_CHANNEL1_FLAG   1
`define BIT_CC2IF   2
`define BIT_TIF     6
`define BIT_CHANNEL1_OVERCAPTURE_FLAG   9
`define BIT_CC2OF   10
`define SWEVT_MASK  16'h0047
`define FLAGS_MASK  16'h0647
`define CTRL_UPDATE_DISABLE   0
`define CTRL_URS    1
`define CTRL_DIR    2
`define CTRL_CC1IN  3
`define CTRL_CC2IN  4
`define CTRL_CEN    5
`define CTRL_MASK   16'h003F
`define RST16       16'h0000
`endif

// ===== src/prescaler.v
`timescale 1ns/1ps
`include "swevt_consts.vh"
module prescaler #(
  parameter W = 16
) (
  // Clock and reset
  input  wire         hclk,
  input  wire         hresetn,
  // Control
  input  wire         run,
  input  wire         clear,
  input  wire [W-1:0] divisor,
  // Tick
  output reg          tick
);
  reg [W-1:0] count_reg;

  // ==========================================
  // Divider: tick once every divisor+1 cycles
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_reg <= {W{1'b0}};
      tick      <= 1'b0;
    end else if (clear) begin
      // Only the internal count resets, the coefficient is untouched
      count_reg <= {W{1'b0}};
      tick      <= 1'b0;
    end else if (run) begin
      tick <= (count_reg == divisor);
      if (count_reg == divisor) begin
        count_reg <= {W{1'b0}};
      end else begin
        count_reg <= count_reg + {{(W-1){1'b0}}, 1'b1};
      end
    end else begin
      tick <= 1'b0;
    end
  end
endmodule // prescaler

// ===== src/channel_flags.v
`timescale 1ns/1ps
`include "swevt_consts.vh"
module channel_flags #(
  parameter W = 16
) (
  // Clock and reset
  input  wire         hclk,
  input  wire         hresetn,
  // Event and mode
  input  wire         force_evt,
  input  wire         is_input,
  input  wire [W-1:0] counter,
  // Software clears
  input  wire         clr_flag,
  input  wire         clr_over,
  // State
  output reg          flag,
  output reg          over,
  output reg  [W-1:0] capture
);
  // ==========================================
  // Forced compare/capture; the set wins over a clear in the same cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag    <= 1'b0;
      over    <= 1'b0;
      capture <= {W{1'b0}};
    end else begin
      if (force_evt) begin
        flag <= 1'b1;
      end else if (clr_flag) begin
        flag <= 1'b0;
      end
      if (force_evt && is_input) begin
        capture <= counter;
      end
      if (force_evt && is_input && flag) begin
        over <= 1'b1;
      end else if (clr_over) begin
        over <= 1'b0;
      end
    end
  end
endmodule // channel_flags

// ===== src/timer_software_event_generation.v
`timescale 1ns/1ps
`include "swevt_consts.vh"
module timer_software_event_generation #(
  parameter W = 16
) (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  // Events to the rest of the timer
  output reg         trigger_pulse,
  output reg         update_pulse,
  // Interrupt
  output wire        irq
);
  // ==========================================
  // Address phase capture
  reg        wr_pend_reg;
  reg        rd_pend_reg;
  reg [11:0] addr_reg;
  wire       start = hsel & hready & htrans[1];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 12'h000;
    end else begin
      wr_pend_reg <= start & hwrite;
      rd_pend_reg <= start & ~hwrite;
      if (start) begin
        addr_reg <= haddr;
      end
    end
  end

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  wire [15:0] wd = hwdata[15:0];
  wire wr_swevt = wr_pend_reg && addr_reg == `OFS_SWEVT;
  wire wr_mask  = wr_pend_reg && addr_reg == `OFS_MASK;
  wire wr_ctrl  = wr_pend_reg && addr_reg == `OFS_CTRL;
  wire wr_cnt   = wr_pend_reg && addr_reg == `OFS_CNT;
  wire wr_arr   = wr_pend_reg && addr_reg == `OFS_ARR;
  wire wr_psc   = wr_pend_reg && addr_reg == `OFS_PSC;
  wire wr_flags = wr_pend_reg && addr_reg == `OFS_FLAGS;
  wire rd_stat  = rd_pend_reg && addr_reg == `OFS_STATUS;

  // ==========================================
  // Generate bits: set by a write of 1, cleared by hardware next cycle
  reg [15:0] gen_reg;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gen_reg <= `RST16;
    end else if (wr_swevt) begin
      // Zeros and reserved bits have no effect
      gen_reg <= wd & `SWEVT_MASK;
    end else begin
      gen_reg <= `RST16;
    end
  end
  wire g_ug  = gen_reg[`BIT_UG];
  wire g_cc1 = gen_reg[`BIT_CHANNEL1_EVENT_GENERATE];
  wire g_cc2 = gen_reg[`BIT_CHANNEL2_EVENT_GENERATE];
  wire g_tg  = gen_reg[`BIT_TG];

  // ==========================================
  // Control, reload, prescaler coefficient
  reg [15:0]  ctrl_reg;
  reg [W-1:0] arr_reg;
  reg [W-1:0] psc_reg;
  reg [15:0]  mask_reg;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= `RST16;
      arr_reg  <= {W{1'b1}};
      psc_reg  <= {W{1'b0}};
      mask_reg <= `RST16;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= wd & `CTRL_MASK;
      end
      if (wr_arr) begin
        arr_reg <= wd[W-1:0];
      end
      if (wr_psc) begin
        psc_reg <= wd[W-1:0];
      end
      if (wr_mask) begin
        mask_reg <= wd & `FLAGS_MASK;
      end
    end
  end
  wire update_disable  = ctrl_reg[`CTRL_UPDATE_DISABLE];
  wire update_request_source   = ctrl_reg[`CTRL_URS];
  wire down  = ctrl_reg[`CTRL_DIR];
  wire cen   = ctrl_reg[`CTRL_CEN];

  // ==========================================
  // Prescaler and core counter
  wire tick;
  prescaler #(.W(W)) u_psc (
    .hclk    (hclk),
    .hresetn (hresetn),
    .run     (cen),
    .clear   (g_ug),
    .divisor (psc_reg),
    .tick    (tick)
  );

  reg [W-1:0] cnt_reg;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= {W{1'b0}};
    end else if (g_ug) begin
      if (down) begin
        cnt_reg <= arr_reg;
      end else begin
        cnt_reg <= {W{1'b0}};
      end
    end else if (wr_cnt) begin
      cnt_reg <= wd[W-1:0];
    end else if (tick) begin
      if (down) begin
        cnt_reg <= (cnt_reg == {W{1'b0}}) ? arr_reg : cnt_reg - {{(W-1){1'b0}}, 1'b1};
      end else begin
        cnt_reg <= (cnt_reg == arr_reg) ? {W{1'b0}} : cnt_reg + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  // ==========================================
  // Event flags
  wire upd_evt = g_ug & ~update_request_source & ~update_disable;
  reg  uif_reg;
  reg  tif_reg;
  wire [15:0] fclr = wr_flags ? ~wd : 16'h0000;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      uif_reg       <= 1'b0;
      tif_reg       <= 1'b0;
      trigger_pulse <= 1'b0;
      update_pulse  <= 1'b0;
    end else begin
      trigger_pulse <= g_tg;
      update_pulse  <= upd_evt;
      if (upd_evt) begin
        uif_reg <= 1'b1;
      end else if (fclr[`BIT_UIF]) begin
        uif_reg <= 1'b0;
      end
      if (g_tg) begin
        tif_reg <= 1'b1;
      end else if (fclr[`BIT_TIF]) begin
        tif_reg <= 1'b0;
      end
    end
  end

  wire c1f;
  wire c1o;
  wire c2f;
  wire c2o;
  wire [W-1:0] ccr1;
  wire [W-1:0] ccr2;
  channel_flags #(.W(W)) u_ch1 (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .force_evt (g_cc1),
    .is_input  (ctrl_reg[`CTRL_CC1IN]),
    .counter   (cnt_reg),
    .clr_flag  (fclr[`BIT_CHANNEL1_FLAG]),
    .clr_over  (fclr[`BIT_CHANNEL1_OVERCAPTURE_FLAG]),
    .flag      (c1f),
    .over      (c1o),
    .capture   (ccr1)
  );
  channel_flags #(.W(W)) u_ch2 (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .force_evt (g_cc2),
    .is_input  (ctrl_reg[`CTRL_CC2IN]),
    .counter   (cnt_reg),
    .clr_flag  (fclr[`BIT_CC2IF]),
    .clr_over  (fclr[`BIT_CC2OF]),
    .flag      (c2f),
    .over      (c2o),
    .capture   (ccr2)
  );

  wire [15:0] flags = {5'h00, c2o, c1o, 2'h0, tif_reg, 3'h0, c2f, c1f, uif_reg};

  // ==========================================
  // Sticky status, cleared by reading it; set wins over the read clear
  reg  [15:0] stat_reg;
  wire [15:0] stat_set = {5'h00, g_cc2 & ctrl_reg[`CTRL_CC2IN] & c2f,
                          g_cc1 & ctrl_reg[`CTRL_CC1IN] & c1f, 2'h0, g_tg,
                          3'h0, g_cc2, g_cc1, upd_evt};
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_reg <= `RST16;
    end else if (rd_stat) begin
      // Clear only the bits the read returned; an event in the address phase survives
      stat_reg <= (stat_reg & ~hrdata[15:0]) | stat_set;
    end else begin
      stat_reg <= stat_reg | stat_set;
    end
  end
  assign irq = |(stat_reg & mask_reg);

  // ==========================================
  // Read data, registered at the end of the address phase
  reg [15:0] rd_mux;
  always @* begin
    case (haddr)
      `OFS_STATUS: rd_mux = stat_reg;
      `OFS_MASK:   rd_mux = mask_reg;
      `OFS_CTRL:   rd_mux = ctrl_reg;
      `OFS_CNT:    rd_mux = cnt_reg;
      `OFS_ARR:    rd_mux = arr_reg;
      `OFS_PSC:    rd_mux = psc_reg;
      `OFS_CCR1:   rd_mux = ccr1;
      `OFS_CCR2:   rd_mux = ccr2;
      `OFS_FLAGS:  rd_mux = flags;
      default:     rd_mux = 16'h0000; // Generate register reads zero
    endcase
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (start & ~hwrite) begin
      hrdata <= {16'h0000, rd_mux};
    end
  end
endmodule // timer_software_event_generation

// ===== verif/swevt_monitor.sv
`timescale 1ns/1ps
module swevt_monitor (
  // Clock and reset
  input wire        hclk,
  input wire        hresetn,
  // Bus
  input wire        hsel,
  input wire [11:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire        hreadyout,
  input wire        hresp,
  input wire [31:0] hrdata,
  // Events
  input wire        trigger_pulse,
  input wire        update_pulse,
  input wire        irq
);
  reg        wr_reg;
  reg        rd_reg;
  reg [11:0] a_reg;
  reg [1:0]  ctl_reg;
  wire       tw = wr_reg && a_reg == 12'h000 && hwdata[6];
  wire       uw = wr_reg && a_reg == 12'h000 && hwdata[0];
  // Shadow of the update controls, so the checker knows when a forced update counts
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      a_reg <= 12'h000;
      ctl_reg <= 2'b00;
    end else begin
      if (wr_reg && a_reg == 12'h00C)
        ctl_reg <= hwdata[1:0];
      if (hready) begin
        wr_reg <= hsel && htrans[1] && hwrite;
        rd_reg <= hsel && htrans[1] && !hwrite;
        a_reg <= haddr;
      end
    end
  end
  // ==========================================
  // Properties
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_ready_high: assert property (hreadyout)
    else $error("hreadyout low");
  chk_resp_okay: assert property (!hresp)
    else $error("error response");
  chk_trig_single: assert property (trigger_pulse |=> !trigger_pulse)
    else $error("trigger pulse too long");
  chk_upd_single: assert property (update_pulse |=> !update_pulse)
    else $error("update pulse too long");
  chk_trig_follows: assert property (tw |-> ##[1:2] trigger_pulse)
    else $error("no trigger pulse");
  chk_trig_cause: assert property ($rose(trigger_pulse) |-> $past(tw) || $past(tw, 2))
    else $error("trigger pulse without write");
  chk_upd_follows: assert property (uw && ctl_reg == 2'b00 |-> ##[1:2] update_pulse)
    else $error("no update pulse");
  chk_upd_blocked: assert property (uw && ctl_reg != 2'b00 |=> !update_pulse [*2])
    else $error("update pulse while blocked");
  chk_gen_reads_zero: assert property (rd_reg && a_reg == 12'h000 |-> hrdata == 32'h0)
    else $error("generate register reads nonzero");
  chk_upper_zero: assert property (rd_reg |-> hrdata[31:16] == 16'h0)
    else $error("upper read data nonzero");
  cover property (trigger_pulse);
  cover property (update_pulse);
  cover property (irq);
endmodule // swevt_monitor

bind timer_software_event_generation swevt_monitor mon (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .trigger_pulse,
  .update_pulse, .irq);

// ===== verif/testbench.sv
`timescale 1ns/1ps
`include "swevt_consts.vh"
module testbench;
  reg         hclk = 1'b0;
  reg         hresetn = 1'b0;
  reg         hsel = 1'b0;
  reg  [11:0] haddr = 12'h000;
  reg  [1:0]  htrans = 2'b00;
  reg         hwrite = 1'b0;
  reg  [31:0] hwdata = 32'h0;
  wire        hreadyout;
  wire        hresp;
  wire [31:0] hrdata;
  wire        trigger_pulse;
  wire        update_pulse;
  wire        irq;
  reg  [31:0] rd;
  integer     n_fail = 0;
  integer     check_count = 0;
  integer     cyc = 0;
  integer     i;
  always #4 hclk = ~hclk;
  timer_software_event_generation #(.W(16)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .trigger_pulse(trigger_pulse), .update_pulse(update_pulse), .irq(irq));
  // ==========================================
  // Tasks
  task check(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task finish_test;
    begin
      $display("checks=%0d mismatches=%0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // Waits are unbounded here; the cycle ceiling below cuts a hang
  task wait_rdy;
    begin
      @(posedge hclk);
      while (hreadyout !== 1'b1)
        @(posedge hclk);
    end
  endtask
  task xfer(input w, input [11:0] a, input [31:0] d);
    begin
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      wait_rdy;
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy;
      rd = hrdata;
    end
  endtask
  task rdc(input [11:0] a, input [31:0] e);
    begin
      xfer(1'b0, a, 32'h0);
      check(rd, e);
    end
  endtask
  task gen(input [31:0] d);
    begin
      xfer(1'b1, `OFS_SWEVT, d);
      repeat (3) @(posedge hclk);
    end
  endtask
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail = n_fail + 1;
      finish_test;
    end
  end
  // ==========================================
  // Tests
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(`OFS_ARR, 32'h0000FFFF);
    rdc(`OFS_FLAGS, 32'h0);
    rdc(`OFS_SWEVT, 32'h0);
    xfer(1'b1, 12'h100, 32'hFFFF);
    rdc(12'h100, 32'h0);
    $display("done reset");
    gen(32'h40);
    check({31'h0, irq}, 32'h0);
    xfer(1'b1, `OFS_MASK, 32'h42);
    repeat (2) @(posedge hclk);
    check({31'h0, irq}, 32'h1);
    rdc(`OFS_STATUS, 32'h40);
    repeat (2) @(posedge hclk);
    check({31'h0, irq}, 32'h0);
    rdc(`OFS_FLAGS, 32'h40);
    rdc(`OFS_SWEVT, 32'h0);
    xfer(1'b1, `OFS_FLAGS, 32'h0);
    $display("done trigger");
    gen(32'h02);
    check({31'h0, irq}, 32'h1);
    rdc(`OFS_STATUS, 32'h02);
    rdc(`OFS_FLAGS, 32'h02);
    xfer(1'b1, `OFS_FLAGS, 32'h0);
    $display("done ch1 output");
    xfer(1'b1, `OFS_CTRL, 32'h08);
    xfer(1'b1, `OFS_CNT, 32'h1234);
    gen(32'h02);
    gen(32'h02);
    rdc(`OFS_FLAGS, 32'h202);
    xfer(1'b1, `OFS_FLAGS, 32'h200);
    rdc(`OFS_FLAGS, 32'h200);
    rdc(`OFS_CCR1, 32'h1234);
    xfer(1'b1, `OFS_FLAGS, 32'h0);
    $display("done ch1 capture");
    xfer(1'b1, `OFS_CTRL, 32'h10);
    xfer(1'b1, `OFS_CNT, 32'h55);
    gen(32'h04);
    rdc(`OFS_CCR2, 32'h55);
    rdc(`OFS_FLAGS, 32'h04);
    xfer(1'b1, `OFS_FLAGS, 32'h0);
    $display("done ch2");
    xfer(1'b1, `OFS_CTRL, 32'h00);
    xfer(1'b1, `OFS_CNT, 32'h777);
    xfer(1'b1, `OFS_PSC, 32'h5);
    gen(32'h01);
    rdc(`OFS_CNT, 32'h0);
    rdc(`OFS_FLAGS, 32'h01);
    rdc(`OFS_PSC, 32'h5);
    xfer(1'b1, `OFS_CTRL, 32'h04);
    xfer(1'b1, `OFS_ARR, 32'h321);
    xfer(1'b1, `OFS_CNT, 32'h10);
    gen(32'h01);
    rdc(`OFS_CNT, 32'h321);
    $display("done update");
    for (i = 1; i < 3; i = i + 1) begin
      xfer(1'b1, `OFS_CTRL, i);
      xfer(1'b1, `OFS_FLAGS, 32'h0);
      gen(32'h01);
      rdc(`OFS_FLAGS, 32'h0);
    end
    $display("done update blocked");
    xfer(1'b1, `OFS_CTRL, 32'h00);
    xfer(1'b1, `OFS_CNT, 32'h99);
    gen(32'h0);
    gen(32'hFFB8);
    rdc(`OFS_CNT, 32'h99);
    rdc(`OFS_FLAGS, 32'h0);
    $display("done zero writes");
    // Counter runs with divisor 5; a forced update restarts the prescaler phase
    xfer(1'b1, `OFS_CTRL, 32'h20);
    repeat (7) @(posedge hclk);
    gen(32'h01);
    repeat (9) @(posedge hclk);
    rdc(`OFS_CNT, 32'h1);
    xfer(1'b1, `OFS_CTRL, 32'h00);
    $display("done prescaler clear");
    finish_test;
  end
endmodule // testbench
